// ---- design/cpu_bus_control.sv ----
// Machine-cycle bus sequencer: address, status, strobes, wait, hold, interrupt
`timescale 1ns/1ns
module cpu_bus_control #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  // Core side
  input  wire cpu_bus_pkg::cycle_req_t req,
  input  wire logic                    req_valid,
  input  wire cpu_bus_pkg::op_event_t  op_ev,
  input  wire logic                    sp_load,
  input  wire logic [15:0]             sp_value,
  input  wire logic                    sp_inc,
  input  wire logic                    sp_dec,
  output logic                         req_ready,
  output logic [DATA_W-1:0]            rdata,
  output logic                         rdata_valid,
  output logic [15:0]                  pc,
  output logic [15:0]                  sp,
  output logic                         irq_taken,
  // Pins
  input  wire logic                    ready,
  input  wire logic                    hold,
  input  wire logic                    irq,
  output logic [ADDR_W-1:0]            addr_out,
  output logic                         addr_oe_n,
  input  wire logic [DATA_W-1:0]       data_in,
  output logic [DATA_W-1:0]            data_out,
  output logic                         data_oe_n,
  output logic                         cycle_start,
  output logic                         bus_input_strobe,
  output logic                         write_n,
  output logic                         wait_out,
  output logic                         bus_grant_ack,
  output logic                         irq_enable_flag
);
  cpu_bus_pkg::bus_state_t  state;
  cpu_bus_pkg::bus_state_t  next_state;
  cpu_bus_pkg::cycle_req_t  cur;
  logic                     ready_s;
  logic                     hold_s;
  logic                     irq_s;
  logic                     take_irq;
  logic                     inta_mode;
  logic                     grant_pend;
  logic                     ie_q;
  logic [7:0]               status;
  logic                     irq_pend;
  cpu_bus_pkg::cycle_kind_t nx_kind;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  sync3 u_ready (.mclk(mclk), .rst(rst), .ce(ce), .din(ready), .dout(ready_s));
  sync3 u_hold  (.mclk(mclk), .rst(rst), .ce(ce), .din(hold),  .dout(hold_s));
  sync3 u_irq   (.mclk(mclk), .rst(rst), .ce(ce), .din(irq),   .dout(irq_s));

  // ----------------------------------------------------------------
  // Cycle classification
  // ----------------------------------------------------------------
  wire is_write = (cur.kind == cpu_bus_pkg::cyc_mem_write) |
                  (cur.kind == cpu_bus_pkg::cyc_stack_write) |
                  (cur.kind == cpu_bus_pkg::cyc_out);
  wire is_read  = ~is_write & (cur.kind != cpu_bus_pkg::cyc_halt);
  // Only a granted bus counts as hold; the idle wait shares that state
  wire in_hold  = (state == cpu_bus_pkg::hold_state) & bus_grant_ack;
  wire halted   = (state == cpu_bus_pkg::halt_state);
  wire fetch_t1 = (state == cpu_bus_pkg::first_bus_state) & inta_mode &
                  (cur.kind == cpu_bus_pkg::cyc_inta);
  // Hold recognised only in second/wait with ready, or halted
  wire hold_ok  = hold_s & (halted |
                  (((state == cpu_bus_pkg::second_bus_state) |
                    (state == cpu_bus_pkg::wait_bus_state)) & ready_s));
  wire start_ok = req_valid & ~grant_pend & ~hold_s;

  // Status word for the cycle being launched, so it stands with cycle start
  always_comb begin
    status = 8'h00;
    status[cpu_bus_pkg::ST_INTA]  = (nx_kind == cpu_bus_pkg::cyc_inta);
    status[cpu_bus_pkg::ST_WO_N]  = ~((nx_kind == cpu_bus_pkg::cyc_mem_write) |
                                      (nx_kind == cpu_bus_pkg::cyc_stack_write) |
                                      (nx_kind == cpu_bus_pkg::cyc_out));
    status[cpu_bus_pkg::ST_STACK] = (nx_kind == cpu_bus_pkg::cyc_stack_write);
    status[cpu_bus_pkg::ST_HALT]  = (nx_kind == cpu_bus_pkg::cyc_halt);
    status[cpu_bus_pkg::ST_OUT]   = (nx_kind == cpu_bus_pkg::cyc_out);
    status[cpu_bus_pkg::ST_FETCH] = (nx_kind == cpu_bus_pkg::cyc_fetch) |
                                    (nx_kind == cpu_bus_pkg::cyc_inta);
    status[cpu_bus_pkg::ST_INP]   = (nx_kind == cpu_bus_pkg::cyc_in);
    status[cpu_bus_pkg::ST_MEMR]  = (nx_kind == cpu_bus_pkg::cyc_fetch) |
                                    (nx_kind == cpu_bus_pkg::cyc_mem_read);
  end

  // ----------------------------------------------------------------
  // Interrupt enable and acceptance
  // ----------------------------------------------------------------
  irq_gate u_irq_gate (
    .mclk            (mclk),
    .rst             (rst),
    .ce              (ce),
    .op_ev           (op_ev),
    .irq             (irq_s),
    .in_hold         (in_hold),
    .halted          (halted),
    .fetch_t1        (fetch_t1),
    .irq_enable_flag (ie_q),
    .take_irq        (take_irq)
  );

  // Acceptance happens at instruction end, often while idle, so it is
  // kept pending until the next cycle starts and becomes acknowledge
  wire accept = take_irq | irq_pend;
  assign nx_kind = (accept || (inta_mode && req.kind == cpu_bus_pkg::cyc_fetch)) ?
                   cpu_bus_pkg::cyc_inta : req.kind;

  // ----------------------------------------------------------------
  // Next bus state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      cpu_bus_pkg::first_bus_state: begin
        next_state = cpu_bus_pkg::second_bus_state;
      end
      cpu_bus_pkg::second_bus_state, cpu_bus_pkg::wait_bus_state: begin
        if (!ready_s) begin
          next_state = cpu_bus_pkg::wait_bus_state;
        end else begin
          next_state = cpu_bus_pkg::third_bus_state;
        end
      end
      cpu_bus_pkg::third_bus_state: begin
        // Write cycles keep the bus one clock past the third state
        if (grant_pend) begin
          next_state = cpu_bus_pkg::hold_state;
        end else if (cur.kind == cpu_bus_pkg::cyc_halt) begin
          next_state = cpu_bus_pkg::halt_state;
        end else if (start_ok) begin
          next_state = cpu_bus_pkg::first_bus_state;
        end else begin
          next_state = cpu_bus_pkg::hold_state;
        end
      end
      cpu_bus_pkg::hold_state: begin
        if (!hold_s && !bus_grant_ack && start_ok) begin
          next_state = cpu_bus_pkg::first_bus_state;
        end
      end
      cpu_bus_pkg::halt_state: begin
        if (hold_s) begin
          next_state = cpu_bus_pkg::hold_state;
        end else if (take_irq) begin
          next_state = cpu_bus_pkg::first_bus_state;
        end
      end
      default: begin
        next_state = cpu_bus_pkg::first_bus_state;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State, cycle capture and program counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state      <= cpu_bus_pkg::hold_state;
      cur        <= '0;
      pc         <= cpu_bus_pkg::PC_RESET;
      grant_pend <= 1'b0;
      inta_mode  <= 1'b0;
      irq_pend   <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      // Instruction end leaves acknowledge mode; a new acceptance wins
      if (op_ev.instr_done) begin
        inta_mode <= 1'b0;
      end
      if (next_state == cpu_bus_pkg::first_bus_state) begin
        cur      <= req;
        cur.kind <= nx_kind;
        irq_pend <= 1'b0;
        if (accept) begin
          inta_mode <= 1'b1;
        end else if (req.kind == cpu_bus_pkg::cyc_fetch && !inta_mode) begin
          pc <= req.addr + 16'h0001;
        end
      end else if (take_irq) begin
        irq_pend <= 1'b1;
      end
      if (hold_ok) begin
        grant_pend <= 1'b1;
      end else if (!hold_s) begin
        grant_pend <= 1'b0;
      end
    end
  end

  // Stack pointer, untouched by reset
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (sp_load) begin
        sp <= sp_value;
      end else if (sp_inc) begin
        sp <= sp + 16'h0001;
      end else if (sp_dec) begin
        sp <= sp - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs, all registered, decoded from the next state or the current one
  // ----------------------------------------------------------------
  wire nx_t1   = (next_state == cpu_bus_pkg::first_bus_state);
  wire nx_t2w  = (next_state == cpu_bus_pkg::second_bus_state) |
                 (next_state == cpu_bus_pkg::wait_bus_state);
  wire nx_t3   = (next_state == cpu_bus_pkg::third_bus_state);
  wire nx_hold = (next_state == cpu_bus_pkg::hold_state);
  // Read grant rises with the third state, write grant a clock later
  wire grant_now = (grant_pend | hold_ok) &
                   ((nx_t3 & is_read) | (state == cpu_bus_pkg::third_bus_state) |
                    nx_hold | halted);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_out         <= '0;
      addr_oe_n        <= 1'b1;
      data_out         <= '0;
      data_oe_n        <= 1'b1;
      cycle_start      <= 1'b0;
      bus_input_strobe <= 1'b0;
      write_n          <= 1'b1;
      wait_out         <= 1'b0;
      bus_grant_ack    <= 1'b0;
      irq_enable_flag  <= 1'b0;
      rdata            <= '0;
      rdata_valid      <= 1'b0;
      req_ready        <= 1'b0;
      irq_taken        <= 1'b0;
    end else if (ce) begin
      irq_enable_flag <= ie_q;
      cycle_start     <= nx_t1;
      req_ready       <= nx_t1;
      irq_taken       <= nx_t1 & accept;
      wait_out        <= (next_state == cpu_bus_pkg::wait_bus_state);
      bus_grant_ack   <= grant_now & hold_s;
      if (nx_t1) begin
        addr_out  <= (req.kind == cpu_bus_pkg::cyc_in || req.kind == cpu_bus_pkg::cyc_out) ?
                     {req.addr[7:0], req.addr[7:0]} : req.addr;
        addr_oe_n <= 1'b0;
        data_out  <= status;
        data_oe_n <= 1'b0;
      end else if (state == cpu_bus_pkg::first_bus_state) begin
        data_out  <= status;
        data_oe_n <= 1'b0;
      end
      if (nx_t2w || (nx_t3 && is_write)) begin
        data_out  <= cur.wdata;
        data_oe_n <= ~is_write;
      end
      bus_input_strobe <= (nx_t2w | nx_t3) & is_read;
      write_n          <= ~((next_state == cpu_bus_pkg::wait_bus_state | nx_t3) & is_write);
      if (state == cpu_bus_pkg::third_bus_state && is_read) begin
        rdata <= data_in;
      end
      rdata_valid <= (state == cpu_bus_pkg::third_bus_state) & is_read;
      // Buses float the clock after the grant rises
      if (bus_grant_ack) begin
        addr_oe_n <= 1'b1;
        data_oe_n <= 1'b1;
      end
    end
  end
endmodule // cpu_bus_control

// ---- design/cpu_bus_pkg.sv ----
// Package of constants and types for the processor bus and control sequencer
package cpu_bus_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 16;
  localparam int          DATA_W     = 8;
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam int          RESET_MIN_CLOCKS = 3;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int ST_INTA  = 0;
  localparam int ST_WO_N  = 1;
  localparam int ST_STACK = 2;
  localparam int ST_HALT  = 3;
  localparam int ST_OUT   = 4;
  localparam int ST_FETCH = 5;
  localparam int ST_INP   = 6;
  localparam int ST_MEMR  = 7;

  // Bus states, Gray coded along first, second, third, wait, hold, halt
  typedef enum logic [2:0] {
    first_bus_state  = 3'b000,
    second_bus_state = 3'b001,
    third_bus_state  = 3'b011,
    wait_bus_state   = 3'b010,
    hold_state       = 3'b110,
    halt_state       = 3'b111
  } bus_state_t;

  // Machine cycle kinds requested by the core
  typedef enum logic [2:0] {
    cyc_fetch = 3'b000,
    cyc_mem_read = 3'b001,
    cyc_mem_write = 3'b011,
    cyc_in = 3'b010,
    cyc_out = 3'b110,
    cyc_inta = 3'b111,
    cyc_halt = 3'b101,
    cyc_stack_write = 3'b100
  } cycle_kind_t;

  // A machine-cycle request from the core
  typedef struct packed {
    cycle_kind_t      kind;
    logic [15:0]      addr;
    logic [7:0]       wdata;
    logic             last;      // Final cycle of the instruction
  } cycle_req_t;

  // Instruction-level effects reported by the core
  typedef struct packed {
    logic enable_irq_op;
    logic mask_irq_op;
    logic instr_done;
  } op_event_t;

endpackage

// ---- design/sync3.sv ----
// Three-stage input synchroniser that accepts a change once stages agree
`timescale 1ns/1ns
module sync3 (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  logic s1;
  logic s2;
  logic s3;

  // ----------------------------------------------------------------
  // Capture chain; s1 feeds only s2 to keep metastability contained
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule // sync3

// ---- design/irq_gate.sv ----
// Interrupt enable flag with delayed arming and acceptance decision
`timescale 1ns/1ns
module irq_gate (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire cpu_bus_pkg::op_event_t op_ev,
  input  wire logic                   irq,
  input  wire logic                   in_hold,
  input  wire logic                   halted,
  input  wire logic                   fetch_t1,
  output logic                        irq_enable_flag,
  output logic                        take_irq
);
  logic armed;
  logic pending_arm;
  wire  sample_point = op_ev.instr_done | halted;

  // Acceptance: enabled, armed, not held
  assign take_irq = irq & irq_enable_flag & armed & ~in_hold & sample_point;

  // ----------------------------------------------------------------
  // Enable flag; arming waits one more instruction end so a return
  // placed right after the enable completes first
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_enable_flag <= 1'b0;
      armed           <= 1'b0;
      pending_arm     <= 1'b0;
    end else if (ce) begin
      if (op_ev.enable_irq_op) begin
        irq_enable_flag <= 1'b1;
        armed           <= 1'b0;
        pending_arm     <= 1'b1;
      end else if (op_ev.mask_irq_op) begin
        irq_enable_flag <= 1'b0;
        pending_arm     <= 1'b0;
      end else if (fetch_t1) begin
        irq_enable_flag <= 1'b0;
      end else if (op_ev.instr_done && pending_arm) begin
        pending_arm <= 1'b0;
        armed       <= 1'b1;
      end
    end
  end
endmodule // irq_gate

// ---- testbench/bus_ctl_chk.sv ----
// Pin-level assertions for the machine-cycle bus sequencer
`timescale 1ns/1ns
module bus_ctl_chk #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              req_ready,
  input wire logic              cycle_start,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic              addr_oe_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe_n,
  input wire logic              bus_input_strobe,
  input wire logic              write_n,
  input wire logic              wait_out,
  input wire logic              bus_grant_ack,
  input wire logic              irq_enable_flag,
  input wire logic              irq_taken,
  input wire logic [15:0]       pc
);
  // ----------------------------------------------
  // Single clock domain, shared clock and reset
  // ----------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Grant already held one clock, so the buses must have let go
  sequence granted;
    bus_grant_ack && $past(bus_grant_ack);
  endsequence

  sync_pulse_a: assert property (cycle_start |=> !cycle_start) else $error("cycle start wider than one clock");
  sync_take_a: assert property (cycle_start |-> req_ready) else $error("cycle start without request taken");
  addr_stands_a: assert property (cycle_start |=> $stable(addr_out) [*2]) else $error("address moved in cycle");
  strobe_dir_a: assert property (bus_input_strobe |-> data_oe_n && write_n) else $error("driving while input");
  wr_driven_a: assert property (!write_n |-> !data_oe_n) else $error("write strobe with data bus floating");
  wr_stable_a: assert property (!write_n && $past(!write_n) |-> $stable(data_out))
    else $error("write data moved under strobe");
  hold_float_a: assert property (granted |-> addr_oe_n && data_oe_n) else $error("bus driven while granted");
  hold_quiet_a: assert property (granted |-> write_n && !bus_input_strobe && !cycle_start)
    else $error("bus cycle while granted");
  wait_still_a: assert property (wait_out |-> $stable(addr_out) && !cycle_start) else $error("wait state moved");
  rst_clear_a: assert property ($fell(rst) |-> pc == 16'h0000 && !bus_grant_ack && !irq_enable_flag)
    else $error("state not cleared by reset");
  irq_gate_a: assert property (irq_taken |-> $past(irq_enable_flag) && !bus_grant_ack)
    else $error("interrupt taken while refused");
  irq_clear_a: assert property (irq_taken |-> ##[0:3] !irq_enable_flag) else $error("enable kept after accept");

  // Main scenarios reached
  cover property (wait_out);
  cover property (!write_n);
  cover property (bus_grant_ack);
  cover property (irq_taken);
endmodule // bus_ctl_chk

bind cpu_bus_control bus_ctl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) bus_ctl_chk_inst (
  .mclk, .rst, .req_ready, .cycle_start, .addr_out, .addr_oe_n, .data_out, .data_oe_n, .bus_input_strobe,
  .write_n, .wait_out, .bus_grant_ack, .irq_enable_flag, .irq_taken, .pc
);

// ---- testbench/mem_io_model.sv ----
// Memory and port model answering the sequencer's bus cycles
`timescale 1ns/1ns
module mem_io_model (
  input  wire logic        mclk,
  input  wire logic        stall,
  input  wire logic [15:0] addr_out,
  input  wire logic [7:0]  data_out,
  input  wire logic        bus_input_strobe,
  input  wire logic        write_n,
  output logic [7:0]       data_in,
  output logic             ready,
  output logic [15:0]      last_waddr,
  output logic [7:0]       last_wdata,
  output logic             wr_bad
);
  logic [7:0] prev = 8'h00;
  logic       wr_q = 1'b0;

  // Drive only under the input strobe; a toggling pattern otherwise so stale data never matches
  assign data_in = bus_input_strobe ? (addr_out[15:8] ^ addr_out[7:0] ^ 8'h5a) : ~prev;
  // Slow device: ready stays low until the bench says the data is valid
  assign ready = ~stall;
  initial wr_bad = 1'b0;

  // Capture writes, flag data that moves while the strobe is low
  always @(posedge mclk) begin
    prev <= data_in;
    wr_q <= ~write_n;
    if (!write_n) begin
      last_waddr <= addr_out;
      last_wdata <= data_out;
      if (wr_q && data_out !== last_wdata) begin
        wr_bad <= 1'b1;
      end
    end
  end
endmodule // mem_io_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the machine-cycle bus sequencer
`timescale 1ns/1ns
module testbench;
  logic                    mclk = 1'b0;
  logic                    rst = 1'b1;
  logic                    ce = 1'b1;
  cpu_bus_pkg::cycle_req_t req = '0;
  logic                    req_valid = 1'b0;
  cpu_bus_pkg::op_event_t  op_ev = '0;
  logic [15:0]             sp_value = 16'h0000;
  logic                    sp_load = 1'b0, sp_inc = 1'b0, sp_dec = 1'b0;
  logic                    hold = 1'b0, irq = 1'b0, stall = 1'b0;
  logic [7:0]              rdata, data_in, data_out, last_wdata;
  logic [15:0]             pc, sp, addr_out, last_waddr;
  logic                    req_ready, rdata_valid, irq_taken, ready, addr_oe_n, data_oe_n, wr_bad;
  logic                    cycle_start, bus_input_strobe, write_n, wait_out, bus_grant_ack, irq_enable_flag;
  int                      err_count = 0, checked = 0, taken_cnt = 0;

  cpu_bus_control cpu_bus_control_inst (.mclk, .rst, .ce, .req, .req_valid, .op_ev, .sp_load, .sp_value,
    .sp_inc, .sp_dec, .req_ready, .rdata, .rdata_valid, .pc, .sp, .irq_taken, .ready, .hold, .irq, .addr_out,
    .addr_oe_n, .data_in, .data_out, .data_oe_n, .cycle_start, .bus_input_strobe, .write_n, .wait_out,
    .bus_grant_ack, .irq_enable_flag);
  mem_io_model mem_io_model_inst (.mclk, .stall, .addr_out, .data_out, .bus_input_strobe, .write_n,
    .data_in, .ready, .last_waddr, .last_wdata, .wr_bad);

  // 25 MHz clock and a count of accepted interrupts
  always #20 mclk = ~mclk;
  always @(posedge mclk) if (irq_taken === 1'b1) taken_cnt <= taken_cnt + 1;

  // ------------------------------------------------
  // Comparison, closing and bounded-wait helpers
  // ------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      err_count++;
      $display("Error at %0t: wait ran out", $time);
      test_done();
    end
  endtask
  // Issue one cycle; I/O port numbers appear on both address bytes
  task automatic start(input cpu_bus_pkg::cycle_kind_t k, input logic [15:0] a, input logic [7:0] d,
                       input int sb, input logic sv, output logic [15:0] ea);
    int n;
    ea = (k inside {cpu_bus_pkg::cyc_in, cpu_bus_pkg::cyc_out}) ? {a[7:0], a[7:0]} : a;
    @(posedge mclk);
    req <= '{k, a, d, 1'b1};
    req_valid <= 1'b1;
    for (n = 0; n < 60 && req_ready !== 1'b1; n++) @(negedge mclk);
    limit(n, 60);
    check(cycle_start, 1'b1);
    check(addr_out, ea);
    check(data_out[sb], sv);
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask
  // Writes are judged by the model's capture, reads by returned data
  task automatic finish(input cpu_bus_pkg::cycle_kind_t k, input logic [15:0] ea, input logic [7:0] d);
    int n;
    if (k inside {cpu_bus_pkg::cyc_mem_write, cpu_bus_pkg::cyc_out, cpu_bus_pkg::cyc_stack_write}) begin
      for (n = 0; n < 50 && write_n !== 1'b0; n++) @(negedge mclk);
      limit(n, 50);
      for (n = 0; n < 50 && write_n !== 1'b1; n++) @(negedge mclk);
      limit(n, 50);
      check({last_waddr, last_wdata}, {ea, d});
      check(wr_bad, 1'b0);
    end else begin
      for (n = 0; n < 50 && rdata_valid !== 1'b1; n++) @(negedge mclk);
      limit(n, 50);
      check(rdata, ea[15:8] ^ ea[7:0] ^ 8'h5a);
    end
  endtask
  task automatic op_pulse(input cpu_bus_pkg::op_event_t e);
    @(posedge mclk);
    op_ev <= e;
    @(posedge mclk);
    op_ev <= '0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic instr;
    logic [15:0] ea;
    start(cpu_bus_pkg::cyc_fetch, 16'h0100, 8'h00, cpu_bus_pkg::ST_OUT, 1'b0, ea);
    finish(cpu_bus_pkg::cyc_fetch, ea, 8'h00);
    op_pulse('{1'b0, 1'b0, 1'b1});
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_reset;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    check({addr_oe_n, data_oe_n, write_n, bus_grant_ack, irq_enable_flag}, 5'h1c);
    check(pc, cpu_bus_pkg::PC_RESET);
    @(posedge mclk);
    rst <= 1'b0;
  endtask
  task automatic t_kinds;
    cpu_bus_pkg::cycle_kind_t ks[6];
    int bs[6];
    logic [15:0] as[6];
    logic [5:0] vs;
    logic [15:0] ea;
    ks = '{cpu_bus_pkg::cyc_fetch, cpu_bus_pkg::cyc_mem_read, cpu_bus_pkg::cyc_in,
           cpu_bus_pkg::cyc_mem_write, cpu_bus_pkg::cyc_out, cpu_bus_pkg::cyc_stack_write};
    bs = '{cpu_bus_pkg::ST_FETCH, cpu_bus_pkg::ST_MEMR, cpu_bus_pkg::ST_INP,
           cpu_bus_pkg::ST_WO_N, cpu_bus_pkg::ST_OUT, cpu_bus_pkg::ST_STACK};
    as = '{16'h0000, 16'hffff, 16'h00a5, 16'h8001, 16'h003c, 16'hfffe};
    vs = 6'h37;
    for (int i = 0; i < 6; i++) begin
      start(ks[i], as[i], as[i][7:0] ^ 8'hc3, bs[i], vs[i], ea);
      finish(ks[i], ea, as[i][7:0] ^ 8'hc3);
    end
    check(pc, 16'h0001);
  endtask
  // Halt cycle, then a bus request honoured while halted
  task automatic t_halt;
    logic [15:0] ea;
    int n;
    start(cpu_bus_pkg::cyc_halt, 16'h0200, 8'h00, cpu_bus_pkg::ST_HALT, 1'b1, ea);
    repeat (6) @(negedge mclk);
    check({bus_grant_ack, wait_out, write_n}, 3'h1);
    @(posedge mclk);
    hold <= 1'b1;
    for (n = 0; n < 20 && bus_grant_ack !== 1'b1; n++) @(negedge mclk);
    limit(n, 20);
    @(negedge mclk);
    check({addr_oe_n, data_oe_n}, 2'h3);
    @(posedge mclk);
    hold <= 1'b0;
    for (n = 0; n < 20 && bus_grant_ack !== 1'b0; n++) @(negedge mclk);
    limit(n, 20);
  endtask
  // Stall with ready low; optionally ask for the bus while stalled
  task automatic t_stall(input logic ask);
    logic [15:0] ea;
    int n;
    @(posedge mclk);
    stall <= 1'b1;
    repeat (5) @(posedge mclk);
    start(cpu_bus_pkg::cyc_mem_read, 16'h4321, 8'h00, cpu_bus_pkg::ST_MEMR, 1'b1, ea);
    hold <= ask;
    repeat (8) @(negedge mclk);
    check({wait_out, rdata_valid, bus_grant_ack}, 3'h4);
    @(posedge mclk);
    stall <= 1'b0;
    finish(cpu_bus_pkg::cyc_mem_read, ea, 8'h00);
    if (ask) begin
      for (n = 0; n < 20 && bus_grant_ack !== 1'b1; n++) @(negedge mclk);
      limit(n, 20);
      repeat (2) @(negedge mclk);
      check({addr_oe_n, data_oe_n, cycle_start}, 3'h6);
      @(posedge mclk);
      hold <= 1'b0;
      for (n = 0; n < 20 && bus_grant_ack !== 1'b0; n++) @(negedge mclk);
      limit(n, 20);
      start(cpu_bus_pkg::cyc_mem_read, 16'h5555, 8'h00, cpu_bus_pkg::ST_MEMR, 1'b1, ea);
      finish(cpu_bus_pkg::cyc_mem_read, ea, 8'h00);
    end
    check(wait_out, 1'b0);
  endtask
  task automatic t_irq;
    @(posedge mclk);
    irq <= 1'b1;
    instr();
    instr();
    check(taken_cnt[15:0], 16'h0000);
    op_pulse('{1'b1, 1'b0, 1'b0});
    check(irq_enable_flag, 1'b1);
    instr();
    check(taken_cnt[15:0], 16'h0000);
    instr();
    instr();
    check({taken_cnt[14:0], irq_enable_flag}, 16'h0002);
    irq <= 1'b0;
    op_pulse('{1'b1, 1'b0, 1'b0});
    op_pulse('{1'b0, 1'b1, 1'b0});
    check(irq_enable_flag, 1'b0);
  endtask
  task automatic t_sp;
    @(posedge mclk);
    sp_value <= 16'hfffe;
    sp_load <= 1'b1;
    @(posedge mclk);
    sp_load <= 1'b0;
    sp_inc <= 1'b1;
    repeat (2) @(posedge mclk);
    sp_inc <= 1'b0;
    sp_dec <= 1'b1;
    @(posedge mclk);
    sp_dec <= 1'b0;
    @(negedge mclk);
    check(sp, 16'hffff);
  endtask

  // Main sequence
  initial begin
    t_reset();
    t_kinds();
    t_stall(1'b0);
    t_stall(1'b1);
    t_halt();
    t_irq();
    t_sp();
    test_done();
  end
endmodule // testbench
